/* logic/bank_pwm.sv */
// sixteen-step pwm generator shared by both display banks
module bank_pwm #(
  parameter int SLICE = 62
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  // levels and enables
  input  wire logic [3:0] main_level_i,
  input  wire logic [3:0] sub_level_i,
  input  wire logic       main_en_i,
  input  wire logic       sub_en_i,
  // sink gates
  output logic            main_on_o,
  output logic            sub_on_o
);
  typedef struct packed {
    logic [15:0] div;
    logic [3:0]  phase;
    logic        main_on;
    logic        sub_on;
  } pwm_state_type;

  pwm_state_type q_r;
  pwm_state_type q_nxt;

  always_comb
  begin
    q_nxt = q_r;
    if (q_r.div == 16'(SLICE - 1))
    begin
      q_nxt.div   = 16'h0000;
      q_nxt.phase = q_r.phase + 4'h1;
    end
    else
    begin
      q_nxt.div = q_r.div + 16'h0001;
    end
    // (RQ24) duty (n+1)/16
    // code 15 compares true on every phase: continuous on
    q_nxt.main_on = main_en_i && (q_r.phase <= main_level_i);
    q_nxt.sub_on  = sub_en_i && (q_r.phase <= sub_level_i);
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      q_r <= '0;
    else
      q_r <= q_nxt;
  end

  assign main_on_o = q_r.main_on;
  assign sub_on_o  = q_r.sub_on;
endmodule : bank_pwm

/* logic/led_brightness_i2c_ctrl.sv */
// two-wire slave with brightness registers and sink control
module led_brightness_i2c_ctrl #(
  parameter bit FAST_OPTION = 1'b0
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  // two-wire bus
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_n_o,
  // sink controls
  output logic [3:0]      main_bank_sinks_o,
  output logic [1:0]      sub_bank_sinks_o,
  output logic            keypad_sink_o,
  output logic [6:0]      keypad_scale_pct_o,
  output logic            pump_force_3x2_o,
  // register view
  output logic [7:0]      bank_enable_control_o,
  output logic [7:0]      display_brightness_levels_o,
  output logic [7:0]      keypad_brightness_level_o,
  output logic            bus_busy_o
);
  typedef struct packed {
    logic [1:0]                     scl_sync;
    logic [1:0]                     sda_sync;
    logic                           scl_d;
    logic                           sda_d;
    led_brightness_pkg::phase_type  phase;
    logic [3:0]                     bitcnt;
    logic [7:0]                     shift;
    logic [7:0]                     reg_sel;
    logic                           ack;
    logic                           busy;
    logic [7:0]                     enables;
    logic [7:0]                     levels;
    logic [7:0]                     keypad;
    logic [6:0]                     key_pct;
    logic                           force_gain;
  } ctrl_state_type;

  ctrl_state_type q_r;
  ctrl_state_type q_nxt;
  logic           main_on;
  logic           sub_on;

  localparam int SLICE = FAST_OPTION ? led_brightness_pkg::PWM_SLICE_FAST
                                     : led_brightness_pkg::PWM_SLICE_SLOW;

  always_comb
  begin
    logic scl;
    logic sda;
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic [7:0] byte_in;
    scl     = q_r.scl_sync[1];
    sda     = q_r.sda_sync[1];
    rise    = scl && !q_r.scl_d;
    fall    = !scl && q_r.scl_d;
    // (RQ2) data falls while clock high
    start   = scl && q_r.scl_d && q_r.sda_d && !sda;
    // (RQ3) data rises while clock high
    stop    = scl && q_r.scl_d && !q_r.sda_d && sda;
    byte_in = {q_r.shift[6:0], sda};
    q_nxt   = q_r;
    // second flop feeds the edge logic and, for data, the shift register
    q_nxt.scl_sync = {q_r.scl_sync[0], scl_i};
    q_nxt.sda_sync = {q_r.sda_sync[0], sda_i};
    q_nxt.scl_d    = scl;
    q_nxt.sda_d    = sda;
    if (start)
    begin
      // (RQ6) repeated start restarts addressing
      q_nxt.phase  = led_brightness_pkg::ST_ADDR;
      q_nxt.bitcnt = 4'h0;
      q_nxt.ack    = 1'b0;
      // (RQ5) busy from start
      q_nxt.busy   = 1'b1;
    end
    else if (stop)
    begin
      // (RQ5) idle after stop
      q_nxt.phase = led_brightness_pkg::ST_IDLE;
      q_nxt.busy  = 1'b0;
      q_nxt.ack   = 1'b0;
    end
    else if (q_r.phase != led_brightness_pkg::ST_IDLE)
    begin
      // (RQ1) sample data only on rising clock
      if (rise && q_r.bitcnt < 4'h8)
      begin
        // (RQ7) msb first, eight bits
        q_nxt.shift  = byte_in;
        q_nxt.bitcnt = q_r.bitcnt + 4'h1;
      end
      else if (fall && q_r.bitcnt == 4'h8)
      begin
        // (RQ9) ack drive starts after eighth falling clock
        q_nxt.bitcnt = 4'h9;
        case (q_r.phase)
          led_brightness_pkg::ST_ADDR:
          begin
            // (RQ10) only our address; (RQ11) write only
            if (q_r.shift[7:1] == led_brightness_pkg::SLAVE_ADDR && !q_r.shift[0])
            begin
              q_nxt.ack = 1'b1;
              q_nxt.phase = led_brightness_pkg::ST_REG;
            end
            else
            begin
              // reads are not served: no data to return
              q_nxt.phase = led_brightness_pkg::ST_IDLE;
            end
          end
          led_brightness_pkg::ST_REG:
          begin
            // (RQ12) second byte selects register
            q_nxt.ack     = 1'b1;
            q_nxt.reg_sel = q_r.shift;
            q_nxt.phase   = led_brightness_pkg::ST_DATA;
          end
          led_brightness_pkg::ST_DATA:
          begin
            // (RQ12) third byte stored; (RQ26) others dropped
            q_nxt.ack = 1'b1;
            if (q_r.reg_sel == led_brightness_pkg::ENABLE_ADDR)
              q_nxt.enables = q_r.shift;
            else if (q_r.reg_sel == led_brightness_pkg::LEVELS_ADDR)
              q_nxt.levels = q_r.shift;
            else if (q_r.reg_sel == led_brightness_pkg::KEYPAD_ADDR)
              q_nxt.keypad = q_r.shift;
          end
          default:
          begin
            q_nxt.phase = led_brightness_pkg::ST_IDLE;
          end
        endcase
      end
      else if (fall && q_r.bitcnt == 4'h9)
      begin
        // (RQ9) release after ninth pulse; (RQ8) master clocked it
        q_nxt.ack    = 1'b0;
        q_nxt.bitcnt = 4'h0;
      end
    end
    // (RQ20) (RQ25) analog keypad step; (RQ21) upper bits ignored
    case (q_r.keypad[led_brightness_pkg::KEY_LVL_LSB +: 2])
      2'h3:    q_nxt.key_pct = led_brightness_pkg::KEY_PCT_3;
      2'h2:    q_nxt.key_pct = led_brightness_pkg::KEY_PCT_2;
      2'h1:    q_nxt.key_pct = led_brightness_pkg::KEY_PCT_1;
      default: q_nxt.key_pct = led_brightness_pkg::KEY_PCT_0;
    endcase
    // (RQ23) keypad alone forces gain 3/2
    q_nxt.force_gain = q_r.enables[led_brightness_pkg::KEY_EN_BIT]
                     && !q_r.enables[led_brightness_pkg::MAIN_EN_BIT]
                     && !q_r.enables[led_brightness_pkg::SUB_EN_BIT];
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      q_r          <= '0;
      q_r.scl_sync <= 2'h3;
      q_r.sda_sync <= 2'h3;
      q_r.scl_d    <= 1'b1;
      q_r.sda_d    <= 1'b1;
      // (RQ13) registers clear at power-on
      q_r.enables  <= led_brightness_pkg::REG_RESET;
      q_r.levels   <= led_brightness_pkg::REG_RESET;
      q_r.keypad   <= led_brightness_pkg::REG_RESET;
      q_r.key_pct  <= led_brightness_pkg::KEY_PCT_0;
    end
    else
    begin
      q_r <= q_nxt;
    end
  end

  // (RQ17) (RQ18) fixed-rate sixteen-step pwm; (RQ16) level fields
  bank_pwm #(
    .SLICE (SLICE)
  ) u_pwm (
    .clk_i        (clk_i),
    .rstn_i       (rstn_i),
    .main_level_i (q_r.levels[led_brightness_pkg::MAIN_LVL_LSB +: 4]),
    .sub_level_i  (q_r.levels[led_brightness_pkg::SUB_LVL_LSB +: 4]),
    .main_en_i    (q_r.enables[led_brightness_pkg::MAIN_EN_BIT]),
    .sub_en_i     (q_r.enables[led_brightness_pkg::SUB_EN_BIT]),
    .main_on_o    (main_on),
    .sub_on_o     (sub_on)
  );

  // (RQ4) device never drives a start or stop: only ack low
  assign sda_o      = 1'b0;
  assign sda_oe_n_o = !q_r.ack;
  // (RQ14) (RQ15) each enable gates its own group
  assign main_bank_sinks_o  = {4{main_on}};
  assign sub_bank_sinks_o   = {2{sub_on}};
  // (RQ22) keypad is steady current, scaled not pulsed
  assign keypad_sink_o      = q_r.enables[led_brightness_pkg::KEY_EN_BIT];
  assign keypad_scale_pct_o = q_r.key_pct;
  assign pump_force_3x2_o   = q_r.force_gain;
  // (RQ19) register view: enables, levels, keypad and busy
  assign bank_enable_control_o       = q_r.enables;
  assign display_brightness_levels_o = q_r.levels;
  assign keypad_brightness_level_o   = q_r.keypad;
  assign bus_busy_o                  = q_r.busy;
endmodule : led_brightness_i2c_ctrl

/* logic/led_brightness_pkg.sv */
// constants for the two-wire led brightness controller
// How it works
// (RQ1) data changes only while clock low, except start and stop
// (RQ2) start: data falls while clock high
// (RQ3) stop: data rises while clock high
// (RQ4) master alone makes start and stop; device never does
// (RQ5) bus busy from start until stop, idle afterwards
// (RQ6) repeated start behaves like a first start, address again
// (RQ7) bytes are eight bits, msb first, then one acknowledge slot
// (RQ8) master clocks the acknowledge slot and releases data high
// (RQ9) device pulls data low for the whole ninth clock pulse
// (RQ10) first byte is seven-bit address plus direction; answer only 36h
// (RQ11) direction zero means write, one means read
// (RQ12) second byte picks register, third byte is stored there
// (RQ13) all three registers clear at power-on, drivers off
// (RQ14) enable register at 10h holds main, sub, keypad enables
// (RQ15) each enable switches its own sink group on
// (RQ16) level register at A0h holds main and sub four-bit levels
// (RQ17) display level picks one of sixteen duty steps of one sixteenth
// (RQ18) display pwm rate fixed at 10kHz or 23kHz by option
// (RQ19) keypad level register at B0h
// (RQ20) keypad codes give 100, 70, 40, 20 percent; 11 is full
// (RQ21) keypad register bits seven to two do nothing
// (RQ22) keypad brightness by analog current step, not pwm
// (RQ23) keypad alone enabled forces charge pump gain 3/2
// (RQ24) display code n gives duty (n+1)/16
// (RQ25) keypad codes 10, 01, 00 give 70, 40, 20 percent
// (RQ26) writes to undefined register address acked and dropped
package led_brightness_pkg;
  localparam logic [6:0] SLAVE_ADDR      = 7'h36;
  localparam logic [7:0] ENABLE_ADDR     = 8'h10;
  localparam logic [7:0] LEVELS_ADDR     = 8'hA0;
  localparam logic [7:0] KEYPAD_ADDR     = 8'hB0;
  localparam logic [7:0] REG_RESET       = 8'h00;
  localparam int         MAIN_EN_BIT     = 0;
  localparam int         SUB_EN_BIT      = 1;
  localparam int         KEY_EN_BIT      = 2;
  localparam int         MAIN_LVL_LSB    = 0;
  localparam int         SUB_LVL_LSB     = 4;
  localparam int         KEY_LVL_LSB     = 0;
  localparam int         CLK_HZ          = 10_000_000;
  localparam int         PWM_HZ_SLOW     = 10_000;
  localparam int         PWM_HZ_FAST     = 23_000;
  localparam int         PWM_STEPS       = 16;
  // analog keypad scale in percent, index is the two-bit code
  localparam logic [6:0] KEY_PCT_0       = 7'h14;
  localparam logic [6:0] KEY_PCT_1       = 7'h28;
  localparam logic [6:0] KEY_PCT_2       = 7'h46;
  localparam logic [6:0] KEY_PCT_3       = 7'h64;
  // cycles per sixteenth of a pwm period, rounded down
  localparam int PWM_SLICE_SLOW = CLK_HZ / (PWM_HZ_SLOW * PWM_STEPS);
  localparam int PWM_SLICE_FAST = CLK_HZ / (PWM_HZ_FAST * PWM_STEPS);

  typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_REG, ST_DATA} phase_type;
endpackage : led_brightness_pkg

/* tb/bus_master_model.sv */
// two-wire bus master model; clock idles high between frames
module bus_master_model (
  // clock and bus
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {scl_o, sda_o} = 2'b11;
  // quarter bus period of two system clocks gives 800 ns
  task automatic step();
    repeat (2) @(posedge clk_i);
  endtask : step
  // start from idle or mid-transfer alike
  task automatic start_cond();
    // let a pending ack release land while the clock is still low
    step();
    sda_o <= 1'b1;
    step();
    scl_o <= 1'b1;
    step();
    sda_o <= 1'b0;
    step();
    scl_o <= 1'b0;
    step();
  endtask : start_cond
  task automatic stop_cond();
    // never move data on the same edge as the clock fall
    step();
    sda_o <= 1'b0;
    step();
    scl_o <= 1'b1;
    step();
    sda_o <= 1'b1;
    step();
  endtask : stop_cond
  // msb first, ninth slot released high
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic [8:0] v;
    v = {b, 1'b1};
    for (int i = 8; i >= 0; i--)
    begin
      step();
      sda_o <= v[i];
      step();
      scl_o <= 1'b1;
      step();
      if (i == 0) ack = !sda_i;
      step();
      scl_o <= 1'b0;
    end
  endtask : send_byte
endmodule : bus_master_model

/* tb/led_brightness_i2c_ctrl_tb.sv */
// self-checking bench for the brightness controller
module led_brightness_i2c_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
`define CHK(a, b) \
  begin checks++; if ((a) !== (b)) begin errors++; \
  $display("Error %0t: got %h want %h", $time, (a), (b)); end end
  logic       clk_i;
  logic       rstn_i;
  logic       scl;
  logic       m_sda;
  logic       sda_line;
  logic       sda_o;
  logic       oe_n;
  logic [3:0] main_sinks;
  logic [1:0] sub_sinks;
  logic       sda_o_fast;
  logic       oe_n_fast;
  logic [3:0] main_fast;
  logic [6:0] pct;
  logic       pump;
  logic       key_sink;
  logic [7:0] en_v;
  logic [7:0] lvl_v;
  logic [7:0] key_v;
  logic       busy;
  logic       ack;
  int         errors;
  int         checks;
  int         cnt;
  logic [6:0] exp_pct [4] = '{7'h14, 7'h28, 7'h46, 7'h64};
  // open drain: pull-up wins unless someone pulls low
  assign sda_line = m_sda & (oe_n | sda_o) & (oe_n_fast | sda_o_fast);
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  bus_master_model i_master (.clk_i(clk_i), .sda_i(sda_line), .scl_o(scl), .sda_o(m_sda));
  led_brightness_i2c_ctrl #(.FAST_OPTION(1'b0)) i_dut (.clk_i(clk_i), .rstn_i(rstn_i),
    .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe_n_o(oe_n),
    .main_bank_sinks_o(main_sinks), .sub_bank_sinks_o(sub_sinks), .keypad_sink_o(key_sink),
    .keypad_scale_pct_o(pct), .pump_force_3x2_o(pump), .bank_enable_control_o(en_v),
    .display_brightness_levels_o(lvl_v), .keypad_brightness_level_o(key_v), .bus_busy_o(busy));
  // second part with the faster pwm option on the same wires
  led_brightness_i2c_ctrl #(.FAST_OPTION(1'b1)) i_dut_fast (.clk_i(clk_i), .rstn_i(rstn_i),
    .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o_fast), .sda_oe_n_o(oe_n_fast),
    .main_bank_sinks_o(main_fast), .sub_bank_sinks_o(), .keypad_sink_o(),
    .keypad_scale_pct_o(), .pump_force_3x2_o(), .bank_enable_control_o(),
    .display_brightness_levels_o(), .keypad_brightness_level_o(), .bus_busy_o());
  task automatic final_report();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : final_report
  task automatic xfer(input logic [7:0] a, input logic [7:0] r, input logic [7:0] d,
                      input logic exp_ack);
    logic [7:0] seq [3];
    seq = '{a, r, d};
    i_master.start_cond();
    for (int i = 0; i < 3; i++)
    begin
      i_master.send_byte(seq[i], ack);
      `CHK(ack, exp_ack)
      `CHK(busy, 1'b1)
    end
    i_master.stop_cond();
    repeat (6) @(posedge clk_i);
    `CHK(busy, 1'b0)
  endtask : xfer
  initial
  begin
    errors = 0;
    checks = 0;
    rstn_i = 1'b0;
    repeat (5) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    `CHK({en_v, lvl_v, key_v}, 24'h000000)
    `CHK(pct, 7'h14)
    xfer(8'h6C, 8'h10, 8'h07, 1'b1);
    xfer(8'h6C, 8'hA0, 8'h3F, 1'b1);
    `CHK({en_v, lvl_v}, 16'h073F)
    `CHK({main_sinks, key_sink, pump}, 6'h3E)
    $display("test writes done");
    for (int k = 0; k < 4; k++)
    begin
      xfer(8'h6C, 8'hB0, 8'hFC | 8'(k), 1'b1);
      `CHK(key_v, 8'hFC | 8'(k))
      `CHK(pct, exp_pct[k])
    end
    $display("test keypad done");
    // wrong address, read direction, then an unmapped register
    xfer(8'h6E, 8'h10, 8'h00, 1'b0);
    xfer(8'h6D, 8'h10, 8'h00, 1'b0);
    xfer(8'h6C, 8'h20, 8'h00, 1'b1);
    `CHK({en_v, lvl_v, key_v}, 24'h073FFF)
    xfer(8'h6C, 8'h10, 8'h04, 1'b1);
    `CHK({main_sinks, sub_sinks, pump}, 7'h01)
    $display("test refusals done");
    // abandoned transfer, then repeated start into the level register
    i_master.start_cond();
    i_master.send_byte(8'h6C, ack);
    `CHK(ack, 1'b1)
    i_master.send_byte(8'hB0, ack);
    `CHK(ack, 1'b1)
    xfer(8'h6C, 8'hA0, 8'h00, 1'b1);
    xfer(8'h6C, 8'h10, 8'h01, 1'b1);
    `CHK({en_v, lvl_v, key_v}, 24'h0100FF)
    // lowest level: one slice of 62 clocks per 992-clock period
    cnt = 0;
    repeat (992)
    begin
      @(posedge clk_i);
      cnt += int'(main_sinks[0]);
    end
    `CHK(cnt, 62)
    // fast option: one slice of 27 clocks per 432-clock period
    cnt = 0;
    repeat (432)
    begin
      @(posedge clk_i);
      cnt += int'(main_fast[0]);
    end
    `CHK(cnt, 27)
    $display("test restart and duty done");
    final_report();
  end
  initial
  begin
    #3_000_000;
    errors++;
    final_report();
  end
endmodule : led_brightness_i2c_ctrl_tb

/* tb/led_brightness_monitor.sv */
// port assertions for the brightness controller
module led_brightness_monitor (
  // clock and reset
  input wire logic       clk_i,
  input wire logic       rstn_i,
  // watched ports
  input wire logic       scl_i,
  input wire logic       sda_i,
  input wire logic       sda_oe_n_o,
  input wire logic [3:0] main_bank_sinks_o,
  input wire logic       keypad_sink_o,
  input wire logic [6:0] keypad_scale_pct_o,
  input wire logic       pump_force_3x2_o,
  input wire logic [7:0] bank_enable_control_o,
  input wire logic [7:0] display_brightness_levels_o,
  input wire logic [7:0] keypad_brightness_level_o,
  input wire logic       bus_busy_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);
  localparam logic [6:0] PCT [4] = '{7'h14, 7'h28, 7'h46, 7'h64};
  logic [7:0] en;
  assign en = bank_enable_control_o;
  // pin-level framing events, seen before the synchronisers
  sequence start_seq;
    scl_i && $fell(sda_i);
  endsequence
  sequence stop_seq;
    scl_i && $rose(sda_i);
  endsequence
  chk_busy_on_start: assert property (start_seq |-> ##[1:5] bus_busy_o)
    else $error("bus not busy after start");
  chk_busy_off_stop: assert property (stop_seq |-> ##[1:5] !bus_busy_o)
    else $error("bus still busy after stop");
  chk_ack_clock_low: assert property ($changed(sda_oe_n_o) |-> !scl_i)
    else $error("data pull changed while clock high");
  chk_pump_keypad_only: assert property ($stable(en) [*3] |->
    pump_force_3x2_o == (en[2] && en[1:0] == 2'h0)) else $error("pump force wrong");
  chk_keypad_sink_en: assert property ($stable(en) [*3] |-> keypad_sink_o == en[2])
    else $error("keypad sink not following enable");
  chk_main_sinks_off: assert property ($stable(en) [*3] ##0 !en[0] |->
    main_bank_sinks_o == 4'h0) else $error("main sinks on while disabled");
  chk_main_full_duty: assert property ((en[0] && display_brightness_levels_o[3:0] == 4'hF) [*4]
    |-> main_bank_sinks_o == 4'hF) else $error("top level not continuously on");
  chk_keypad_scale_map: assert property ($stable(keypad_brightness_level_o) [*3] |->
    keypad_scale_pct_o == PCT[keypad_brightness_level_o[1:0]]) else $error("keypad scale wrong");
endmodule : led_brightness_monitor

bind led_brightness_i2c_ctrl led_brightness_monitor i_mon (.clk_i, .rstn_i, .scl_i, .sda_i,
  .sda_oe_n_o, .main_bank_sinks_o, .keypad_sink_o, .keypad_scale_pct_o, .pump_force_3x2_o,
  .bank_enable_control_o, .display_brightness_levels_o, .keypad_brightness_level_o,
  .bus_busy_o);
